// [dv/bus_partner.sv]
// wired bus and far-side transceiver as seen by the node comparator
module bus_partner (
    input wire logic line_out_a,
    input wire logic line_out_a_oe_n,
    input wire logic ref_gen_en,
    input wire logic fail_b,
    input wire logic fail_a,
    output logic cmp_a_vs_b,
    output logic cmp_a_vs_ref,
    output logic cmp_ref_vs_b
);
    timeunit 1ns;
    timeprecision 1ps;
    logic bus_rec;
    // a released pin leaves the bus recessive, a driven zero wins
    assign bus_rec = line_out_a_oe_n || line_out_a;
    // a broken wire reads dominant wherever it is used
    assign cmp_a_vs_b = bus_rec && !fail_a && !fail_b;
    assign cmp_ref_vs_b = bus_rec && !fail_b;
    // no generator and no outside source: reference is garbage
    assign cmp_a_vs_ref = !fail_a
        && (ref_gen_en ? bus_rec : !bus_rec);
endmodule // bus_partner

// [dv/can_node_monitor.sv]
// concurrent checks on the node cpu port, reference and reset pin
module can_node_monitor (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [4:0] mem_addr,
    input wire logic mem_wr,
    input wire logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata,
    input wire logic ref_gen_en,
    input wire logic program_from_external,
    input wire logic wdt_expire,
    input wire logic pd_wake,
    input wire logic rst_pin_oe_n
);
    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic [7:0] low_q;
    logic [7:0] low_d;
    // length of the reset pin pulse, restarts whenever the pin is let go
    assign low_d = rst_pin_oe_n ? 8'h00 : low_q + 8'h01;
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            low_q <= 8'h00;
        else
            low_q <= low_d;
    end
    unmapped_zero_a: assert property (
        mem_addr >= 5'h1E |=> mem_rdata == 8'h00)
        else $error("unmapped address read not zero");
    cmd_zero_a: assert property (
        mem_addr == 5'h01 |=> mem_rdata == 8'h00)
        else $error("command byte read not zero");
    storage_rw_a: assert property (
        mem_wr && mem_addr == 5'h03 ##1 mem_addr == 5'h03
        |=> mem_rdata == $past(mem_wdata, 2))
        else $error("storage byte lost its value");
    pulse_start_a: assert property (
        wdt_expire || pd_wake |=> !rst_pin_oe_n [*8])
        else $error("reset pin pulse missing");
    pulse_len_a: assert property (
        $rose(rst_pin_oe_n) |-> low_q == 8'h7D)
        else $error("reset pin pulse length wrong");
    prog_hold_a: assert property (
        $past(rst_n, 2) |-> $stable(program_from_external))
        else $error("program select changed while running");
    ref_off_a: assert property (
        mem_wr && mem_addr == 5'h08 && mem_wdata[2] |=> ##1 !ref_gen_en)
        else $error("reference generator not switched off");
    ref_on_a: assert property (
        mem_wr && mem_addr == 5'h08 && !mem_wdata[2] |=> ##1 ref_gen_en)
        else $error("reference generator not switched on");
endmodule // can_node_monitor

bind can_node can_node_monitor i_can_node_monitor (
    .core_clk(core_clk), .rst_n(rst_n), .mem_addr(mem_addr),
    .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .ref_gen_en(ref_gen_en), .program_from_external(program_from_external),
    .wdt_expire(wdt_expire), .pd_wake(pd_wake),
    .rst_pin_oe_n(rst_pin_oe_n));

// [dv/tb_top.sv]
// self-checking bench for the network node
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, rst_n, mem_wr, cab, car, crb, oa, oa_n, ob, ob_n;
    logic [4:0] mem_addr;
    logic [7:0] mem_wdata, mem_rdata, v;
    logic ref_en, psel, pext, wdt, pdw, rpo, rpo_n, fail_b, fail_a;
    int failures, n_tests;

    can_node i_can_node (.core_clk(core_clk), .rst_n(rst_n),
        .mem_addr(mem_addr), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .cmp_a_vs_b(cab), .cmp_a_vs_ref(car),
        .cmp_ref_vs_b(crb), .line_out_a(oa), .line_out_a_oe_n(oa_n),
        .line_out_b(ob), .line_out_b_oe_n(ob_n), .ref_gen_en(ref_en),
        .external_program_select(psel), .program_from_external(pext),
        .wdt_expire(wdt), .pd_wake(pdw), .rst_pin_out(rpo),
        .rst_pin_oe_n(rpo_n));
    bus_partner i_bus_partner (.line_out_a(oa), .line_out_a_oe_n(oa_n),
        .ref_gen_en(ref_en), .fail_b(fail_b), .fail_a(fail_a),
        .cmp_a_vs_b(cab), .cmp_a_vs_ref(car), .cmp_ref_vs_b(crb));

    // ****************************************************************
    // access tasks
    // ****************************************************************
    task automatic check(input string what, input logic [7:0] e,
        input logic [7:0] g);
        n_tests++;
        if (g !== e)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask
    // two edges per write so the strobe never toggles twice in a step
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        mem_addr <= a;
        mem_wdata <= d;
        mem_wr <= 1'b1;
        @(posedge core_clk);
        mem_wr <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [4:0] a);
        mem_addr <= a;
        @(posedge core_clk);
        @(negedge core_clk);
        v = mem_rdata;
        @(posedge core_clk);
    endtask
    task automatic pulse(input logic w);
        int n;
        n = 0;
        wdt <= w;
        pdw <= !w;
        @(posedge core_clk);
        wdt <= 1'b0;
        pdw <= 1'b0;
        @(negedge core_clk);
        while (rpo_n === 1'b0 && n < 300)
        begin
            n++;
            @(negedge core_clk);
        end
        @(posedge core_clk);
        check("reset pulse", 8'h7D, 8'(n));
        check("reset pin level", 8'h00, {7'h00, rpo});
    endtask
    // expected {oe_n, level} for an idle recessive bit, level 0 if off
    function automatic logic [7:0] stage(input logic [2:0] c);
        case (c[1:0])
            can_node_pkg::OM_PUSH_PULL: stage = {7'h00, !c[2]};
            can_node_pkg::OM_OPEN_DRAIN: stage = c[2] ? 8'h00 : 8'h02;
            can_node_pkg::OM_OPEN_SOURCE: stage = c[2] ? 8'h02 : 8'h01;
            default: stage = 8'h02;
        endcase
    endfunction
    // start a frame, see it go dominant, then wait for completion
    task automatic send();
        int n;
        n = 0;
        wr(5'h01, 8'h01);
        while (oa !== 1'b0 && n < 2000)
        begin
            n++;
            @(posedge core_clk);
        end
        rd(5'h02);
        check("tx access", 8'h00, v & 8'h04);
        while (v[2] !== 1'b1 && n < 6000)
        begin
            n++;
            rd(5'h02);
        end
        check("frame status", 8'h0C, v & 8'h4C);
    endtask
    task automatic results();
        $display("failures %0d of %0d checks", failures, n_tests);
        if (failures == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ****************************************************************
    // stimulus
    // ****************************************************************
    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    // generous bound: three frames of about 5000 cycles each
    initial
    begin
        repeat (40000) @(posedge core_clk);
        failures++;
        results();
    end
    initial
    begin
        {rst_n, mem_wr, wdt, pdw, fail_a, fail_b, psel} = 7'h00;
        mem_addr = 5'h00;
        mem_wdata = 8'h00;
        failures = 0;
        n_tests = 0;
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        psel <= 1'b1;
        rd(5'h00);
        check("control reset", 8'h01, v);
        rd(5'h07);
        check("output control", 8'h1B, v);
        check("program select", 8'h01, {7'h00, pext});
        check("reference on", 8'h01, {7'h00, ref_en});
        wr(5'h02, 8'hFF);
        rd(5'h02);
        check("status", 8'h04, v);
        wr(5'h03, 8'hA5);
        rd(5'h03);
        check("storage", 8'hA5, v);
        rd(5'h1F);
        check("unmapped", 8'h00, v);
        pulse(1'b1);
        pulse(1'b0);
        for (int c = 0; c < 8; c++)
        begin
            wr(5'h07, 8'(c) | 8'((7 - c) << 3));
            repeat (2) @(posedge core_clk);
            @(negedge core_clk);
            check("line a", stage(3'(c)),
                {6'h00, oa_n, !oa_n & oa});
            check("line b", stage(3'(7 - c)),
                {6'h00, ob_n, !ob_n & ob});
            @(posedge core_clk);
        end
        wr(5'h07, 8'h1B);
        wr(5'h08, 8'h04);
        @(negedge core_clk);
        check("reference off", 8'h00, {7'h00, ref_en});
        @(posedge core_clk);
        wr(5'h08, 8'h00);
        wr(5'h05, 8'h0F);
        wr(5'h00, 8'h00);
        wr(5'h0A, 8'h55);
        wr(5'h0B, 8'h01);
        wr(5'h0C, 8'hC3);
        send();
        fail_b <= 1'b1;
        wr(5'h08, 8'h01);
        send();
        // wire a broken, single wire b against the reference
        {fail_a, fail_b} <= 2'h2;
        wr(5'h08, 8'h03);
        send();
        results();
    end
endmodule // tb_top

// [logic/can_node.sv]
// network node: cpu buffers, bit engine, line interface
module can_node (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [4:0] mem_addr,
    input wire logic mem_wr,
    input wire logic [7:0] mem_wdata,
    output logic [7:0] mem_rdata,
    input wire logic cmp_a_vs_b,
    input wire logic cmp_a_vs_ref,
    input wire logic cmp_ref_vs_b,
    output logic line_out_a,
    output logic line_out_a_oe_n,
    output logic line_out_b,
    output logic line_out_b_oe_n,
    output logic ref_gen_en,
    input wire logic external_program_select,
    output logic program_from_external,
    input wire logic wdt_expire,
    input wire logic pd_wake,
    output logic rst_pin_out,
    output logic rst_pin_oe_n
);
    typedef enum logic [1:0] {ST_IDLE, ST_SOF, ST_FRAME, ST_EOF} state_t;

    // ****************************************************************
    // storage
    // ****************************************************************
    localparam int BUF_BYTES_L = can_node_pkg::BUF_BYTES;
    logic [7:0] seg_q [BUF_BYTES_L];
    logic [7:0] tx_mem [BUF_BYTES_L];
    logic [7:0] rx_mem [2][BUF_BYTES_L];
    logic [7:0] mem_rdata_q;
    logic [3:0] sync1_q, sync2_q;
    logic prog_sel_q, prog_done_q, ref_en_q;
    logic [7:0] rst_cnt_q;
    logic rst_oe_n_q;
    state_t state_q;
    logic [7:0] presc_q;
    logic [2:0] tq_q, run_q, eof_q;
    logic [6:0] bit_cnt_q, frame_bits_q;
    logic [7:0] shift_q;
    logic last_q, rx_prev_q, tx_bit_q, tx_active_q, tx_pending_q;
    logic tx_done_q, overrun_q, err_q, keep_q;
    logic wr_bank_q, rd_bank_q;
    logic [1:0] rx_full_q;

    // ****************************************************************
    // cpu port decode
    // ****************************************************************
    wire in_seg = mem_addr < can_node_pkg::SEG_BYTES;
    wire in_tx = !in_seg && mem_addr < can_node_pkg::RX_BASE;
    wire in_rx = mem_addr >= can_node_pkg::RX_BASE
        && mem_addr < can_node_pkg::MAP_END;
    wire [3:0] seg_idx = mem_addr[3:0];
    wire [3:0] tx_idx = 4'(mem_addr - can_node_pkg::TX_BASE);
    wire [3:0] rx_idx = 4'(mem_addr - can_node_pkg::RX_BASE);
    wire cmd_wr = mem_wr && in_seg && seg_idx == can_node_pkg::A_CMD;
    wire tx_req = cmd_wr && mem_wdata[can_node_pkg::CMD_TX_REQ];
    wire abort = cmd_wr && mem_wdata[can_node_pkg::CMD_ABORT];
    wire release_rx = cmd_wr && mem_wdata[can_node_pkg::CMD_RELEASE];
    wire clr_ovr = cmd_wr && mem_wdata[can_node_pkg::CMD_CLR_OVR];
    wire seg_wr = mem_wr && in_seg && seg_idx != can_node_pkg::A_CMD
        && seg_idx != can_node_pkg::A_STAT;
    // buffer is locked while a frame waits, so a queued frame stays intact
    wire tx_wr = mem_wr && in_tx && !tx_pending_q;
    wire reset_req = seg_q[can_node_pkg::A_CTRL][can_node_pkg::CTL_RESET_REQ];
    wire [7:0] cmp_cfg = seg_q[can_node_pkg::A_CMPCTL];
    wire [7:0] out_cfg = seg_q[can_node_pkg::A_OUTCTL];

    can_node_pkg::status_t status;
    assign status = '{bus_off: 1'b0, error: err_q,
        tx_busy: tx_active_q, rx_busy: state_q != ST_IDLE,
        tx_done: tx_done_q, tx_access: !tx_pending_q,
        overrun: overrun_q, rx_ready: rx_full_q[rd_bank_q]};

    // cpu reads the older full bank while the engine fills the other
    wire [7:0] seg_rd = (seg_idx == can_node_pkg::A_STAT) ? status
        : (seg_idx == can_node_pkg::A_CMD) ? 8'h00 : seg_q[seg_idx];
    wire [7:0] rd_mux = in_seg ? seg_rd : in_tx ? tx_mem[tx_idx]
        : in_rx ? rx_mem[rd_bank_q][rx_idx] : 8'h00;

    // ten byte control segment, command and status not stored
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < BUF_BYTES_L; i++)
                seg_q[i] <= can_node_pkg::SEG_RST;
            seg_q[can_node_pkg::A_CTRL] <= can_node_pkg::CTRL_RST;
            seg_q[can_node_pkg::A_OUTCTL] <= can_node_pkg::OUTCTL_RST;
        end
        else if (seg_wr)
            seg_q[seg_idx] <= mem_wdata;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            mem_rdata_q <= 8'h00;
        else
            mem_rdata_q <= rd_mux;
    end

    // ****************************************************************
    // line interface
    // ****************************************************************
    // pins pass two flops before any logic looks at them
    always_ff @(posedge core_clk)
    begin
        sync1_q <= {external_program_select, cmp_ref_vs_b,
            cmp_a_vs_ref, cmp_a_vs_b};
        sync2_q <= sync1_q;
    end

    // single wire: one line against the reference, survives a broken wire
    wire rx_bit = !cmp_cfg[can_node_pkg::CMP_SINGLE] ? sync2_q[0]
        : cmp_cfg[can_node_pkg::CMP_USE_B] ? sync2_q[2]
        : sync2_q[1];

    // the select pin is caught once, on the first edge after release
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prog_sel_q <= 1'b0;
            prog_done_q <= 1'b0;
            ref_en_q <= 1'b1;
        end
        else
        begin
            if (!prog_done_q)
                prog_sel_q <= !sync2_q[3];
            prog_done_q <= 1'b1;
            ref_en_q <= !cmp_cfg[can_node_pkg::CMP_EXT_REF];
        end
    end

    // internal reset causes stretch a low pulse onto the reset pin
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_cnt_q <= 8'h00;
            rst_oe_n_q <= 1'b1;
        end
        else
        begin
            if (wdt_expire || pd_wake)
                rst_cnt_q <= can_node_pkg::RST_PULSE_CYC;
            else if (rst_cnt_q != 8'h00)
                rst_cnt_q <= rst_cnt_q - 8'h01;
            rst_oe_n_q <= !(wdt_expire || pd_wake || rst_cnt_q > 8'h01);
        end
    end

    can_node_pkg::out_cfg_t drv_cfg [2];
    logic [1:0] pin_o, pin_oe_n;
    assign drv_cfg[0] = out_cfg[2:0];
    assign drv_cfg[1] = out_cfg[can_node_pkg::OUT_B_LSB +: 3];

    // both outputs carry the same bit, each with its own stage setting
    for (genvar g = 0; g < 2; g++)
    begin : g_drv
        line_driver u_drv (
            .core_clk(core_clk),
            .rst_n(rst_n),
            .cfg(drv_cfg[g]),
            .tx_bit(tx_bit_q),
            .pin_out(pin_o[g]),
            .pin_oe_n(pin_oe_n[g])
        );
    end

    // ****************************************************************
    // bit timing
    // ****************************************************************
    // prescaler clamped so a bit never runs faster than the limit
    wire [7:0] brp_raw = seg_q[can_node_pkg::A_TIME0];
    wire [7:0] brp = (brp_raw < can_node_pkg::MIN_BRP)
        ? can_node_pkg::MIN_BRP : brp_raw;
    wire tq_en = presc_q == brp;
    wire fall = state_q == ST_IDLE && rx_prev_q && !rx_bit;
    wire sample = tq_en && tq_q == can_node_pkg::SAMPLE_TQ;
    wire bit_start = tq_en && tq_q == can_node_pkg::TQ_LAST;

    // hard sync on a start edge realigns the bit grid
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            presc_q <= 8'h00;
            tq_q <= 3'h0;
            rx_prev_q <= 1'b1;
        end
        else
        begin
            rx_prev_q <= rx_bit;
            presc_q <= (tq_en || fall) ? 8'h00 : presc_q + 8'h01;
            if (fall)
                tq_q <= 3'h0;
            else if (tq_en)
                tq_q <= tq_q + 3'h1;
        end
    end

    // ****************************************************************
    // frame engine
    // ****************************************************************
    wire in_frame = state_q == ST_FRAME;
    wire stuff_slot = run_q == can_node_pkg::STUFF_RUN;
    wire [3:0] byte_idx = bit_cnt_q[6:3];
    wire [7:0] new_byte = {shift_q[6:0], rx_bit};
    wire data_sample = sample && in_frame && !stuff_slot;
    wire byte_done = data_sample && bit_cnt_q[2:0] == 3'h7;
    wire last_bit = data_sample && bit_cnt_q == frame_bits_q - 7'h01;
    wire [3:0] dlc = new_byte[3:0] > can_node_pkg::MAX_DATA
        ? can_node_pkg::MAX_DATA : new_byte[3:0];
    wire [3:0] ndata = new_byte[can_node_pkg::RTR_BIT] ? 4'h0 : dlc;
    wire tx_data = tx_mem[byte_idx][3'h7 - bit_cnt_q[2:0]];
    wire next_tx = stuff_slot ? !last_q : tx_data;
    // a recessive bit overwritten during arbitration means we lost
    wire arb_lost = data_sample && tx_active_q && bit_cnt_q
        < can_node_pkg::ARB_BITS && tx_bit_q && !rx_bit;
    wire stuff_err = sample && in_frame && stuff_slot && rx_bit == last_q;
    wire bit_err = sample && tx_active_q && !arb_lost
        && state_q != ST_IDLE && rx_bit != tx_bit_q;
    wire eof_err = sample && state_q == ST_EOF && !rx_bit;
    wire frame_err = stuff_err || bit_err || eof_err;
    wire frame_ok = sample && state_q == ST_EOF && rx_bit
        && eof_q == can_node_pkg::EOF_BITS - 3'h1;
    wire tx_start = state_q == ST_IDLE && tx_pending_q && !tx_active_q
        && !reset_req && bit_start && rx_bit;

    // buffers hold no control state, so they need no reset
    always_ff @(posedge core_clk)
    begin
        if (tx_wr)
            tx_mem[tx_idx] <= mem_wdata;
        if (byte_done && keep_q)
            rx_mem[wr_bank_q][byte_idx] <= new_byte;
    end

    // bit counters and receive shifter, stuff bits never counted
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= ST_IDLE;
            bit_cnt_q <= 7'h00;
            frame_bits_q <= can_node_pkg::DESC_BITS;
            run_q <= 3'h0;
            last_q <= 1'b1;
            shift_q <= 8'h00;
            eof_q <= 3'h0;
        end
        else if (reset_req || frame_err || frame_ok)
            state_q <= ST_IDLE;
        else if (fall)
            state_q <= ST_SOF;
        else if (sample && state_q == ST_SOF)
        begin
            state_q <= rx_bit ? ST_IDLE : ST_FRAME;
            bit_cnt_q <= 7'h00;
            frame_bits_q <= can_node_pkg::DESC_BITS;
            run_q <= 3'h1;
            last_q <= 1'b0;
        end
        else if (sample && in_frame)
        begin
            run_q <= (rx_bit == last_q) ? run_q + 3'h1 : 3'h1;
            last_q <= rx_bit;
            if (!stuff_slot)
            begin
                shift_q <= new_byte;
                bit_cnt_q <= bit_cnt_q + 7'h01;
                if (byte_done && byte_idx == 4'h1)
                    frame_bits_q <= can_node_pkg::DESC_BITS
                        + {ndata[3:0], 3'h0};
                if (last_bit)
                begin
                    state_q <= ST_EOF;
                    eof_q <= 3'h0;
                end
            end
        end
        else if (sample && state_q == ST_EOF)
            eof_q <= eof_q + 3'h1;
    end

    // transmit side drives its bit at each bit boundary
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_bit_q <= 1'b1;
            tx_active_q <= 1'b0;
            tx_pending_q <= 1'b0;
            tx_done_q <= 1'b0;
        end
        else
        begin
            if (tx_start)
            begin
                tx_active_q <= 1'b1;
                tx_bit_q <= 1'b0;
            end
            else if (arb_lost || frame_err || reset_req || frame_ok)
            begin
                tx_active_q <= 1'b0;
                tx_bit_q <= 1'b1;
            end
            else if (bit_start && in_frame)
                tx_bit_q <= tx_active_q ? next_tx : 1'b1;
            else if (bit_start && state_q == ST_EOF)
                tx_bit_q <= 1'b1;
            // a frame already on the wire is not stopped by abort
            if (frame_ok && tx_active_q)
                tx_pending_q <= 1'b0;
            else if (tx_req)
                tx_pending_q <= 1'b1;
            else if (abort && !tx_active_q)
                tx_pending_q <= 1'b0;
            if (frame_ok && tx_active_q)
                tx_done_q <= 1'b1;
            else if (tx_req)
                tx_done_q <= 1'b0;
        end
    end

    // alternate banks; a new frame lands only in a free bank
    wire commit = frame_ok && keep_q && !tx_active_q;
    wire drop = frame_ok && !keep_q && !tx_active_q;
    wire do_release = release_rx && rx_full_q[rd_bank_q];
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_bank_q <= 1'b0;
            rd_bank_q <= 1'b0;
            rx_full_q <= 2'h0;
            keep_q <= 1'b0;
            overrun_q <= 1'b0;
            err_q <= 1'b0;
        end
        else
        begin
            if (sample && state_q == ST_SOF)
                keep_q <= !rx_full_q[wr_bank_q];
            if (commit)
            begin
                rx_full_q[wr_bank_q] <= 1'b1;
                wr_bank_q <= !wr_bank_q;
            end
            if (do_release)
            begin
                rx_full_q[rd_bank_q] <= 1'b0;
                rd_bank_q <= !rd_bank_q;
            end
            // a new event wins over a clear in the same cycle
            overrun_q <= drop || (overrun_q && !clr_ovr);
            err_q <= frame_err || (err_q && !tx_req);
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign mem_rdata = mem_rdata_q;
    assign line_out_a = pin_o[0];
    assign line_out_a_oe_n = pin_oe_n[0];
    assign line_out_b = pin_o[1];
    assign line_out_b_oe_n = pin_oe_n[1];
    assign ref_gen_en = ref_en_q;
    assign program_from_external = prog_sel_q;
    assign rst_pin_out = 1'b0; // open drain: only ever pulls low
    assign rst_pin_oe_n = rst_oe_n_q;
endmodule // can_node

// [logic/can_node_pkg.sv]
// shared constants, field layouts and carrier types of the network node
// ****************************************************************
// Overview of operation
// - ten byte control segment for cpu
// - transmit buffer: descriptor plus eight data bytes
// - two ten byte receive memories, filled alternately
// - receive next frame while cpu reads other
// - each output: drain, source, push-pull, polarity
// - logical one or idle gives recessive level
// - comparator: a above b is recessive
// - software selects single wire against reference
// - internal reference default, software can disable
// - program select pin sampled only at reset
// - internal reset causes pulse the reset pin
// - programmable bit rate, at most one megabit
// ****************************************************************
package can_node_pkg;

    // memory map of the cpu port, byte addresses
    localparam logic [4:0] SEG_BYTES = 5'h0A;
    localparam logic [4:0] TX_BASE = 5'h0A;
    localparam logic [4:0] RX_BASE = 5'h14;
    localparam logic [4:0] MAP_END = 5'h1E;
    localparam int BUF_BYTES = 10;

    // control segment slots
    localparam logic [3:0] A_CTRL = 4'h0;
    localparam logic [3:0] A_CMD = 4'h1;
    localparam logic [3:0] A_STAT = 4'h2;
    localparam logic [3:0] A_TIME0 = 4'h5;
    localparam logic [3:0] A_OUTCTL = 4'h7;
    localparam logic [3:0] A_CMPCTL = 4'h8;

    // bit positions
    localparam int CTL_RESET_REQ = 0;
    localparam int CMD_TX_REQ = 0;
    localparam int CMD_ABORT = 1;
    localparam int CMD_RELEASE = 2;
    localparam int CMD_CLR_OVR = 3;
    localparam int CMP_SINGLE = 0;
    localparam int CMP_USE_B = 1;
    localparam int CMP_EXT_REF = 2;
    localparam int OUT_B_LSB = 3;
    localparam int RTR_BIT = 4;

    // reset values
    localparam logic [7:0] CTRL_RST = 8'h01;
    localparam logic [7:0] OUTCTL_RST = 8'h1B;
    localparam logic [7:0] SEG_RST = 8'h00;

    // output stage modes
    localparam logic [1:0] OM_FLOAT = 2'h0;
    localparam logic [1:0] OM_OPEN_DRAIN = 2'h1;
    localparam logic [1:0] OM_OPEN_SOURCE = 2'h2;
    localparam logic [1:0] OM_PUSH_PULL = 2'h3;

    // frame layout in bits, data length in bytes
    localparam logic [6:0] DESC_BITS = 7'h10;
    localparam logic [6:0] ARB_BITS = 7'h0C;
    localparam logic [3:0] MAX_DATA = 4'h8;
    localparam logic [2:0] STUFF_RUN = 3'h5;
    localparam logic [2:0] EOF_BITS = 3'h7;

    // timing
    localparam int CLK_NS = 8;
    localparam int BIT_MIN_NS = 1000;
    localparam int BIT_MIN_CYC = (BIT_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int TQ_PER_BIT = 8;
    localparam logic [2:0] TQ_LAST = 3'(TQ_PER_BIT - 1);
    localparam logic [2:0] SAMPLE_TQ = 3'h5;
    localparam logic [7:0] MIN_BRP =
        8'((BIT_MIN_CYC + TQ_PER_BIT - 1) / TQ_PER_BIT - 1);
    localparam int RST_PULSE_NS = 1000;
    localparam logic [7:0] RST_PULSE_CYC =
        8'((RST_PULSE_NS + CLK_NS - 1) / CLK_NS);

    typedef struct packed {
        logic invert;
        logic [1:0] mode;
    } out_cfg_t;

    typedef struct packed {
        logic bus_off;
        logic error;
        logic tx_busy;
        logic rx_busy;
        logic tx_done;
        logic tx_access;
        logic overrun;
        logic rx_ready;
    } status_t;

endpackage

// [logic/line_driver.sv]
// one programmable transmit output stage
module line_driver (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire can_node_pkg::out_cfg_t cfg,
    input wire logic tx_bit,
    output logic pin_out,
    output logic pin_oe_n
);
    logic level;
    logic drive;

    // polarity first, then mode decides which levels are driven
    assign level = tx_bit ^ cfg.invert;
    assign drive = (cfg.mode == can_node_pkg::OM_PUSH_PULL)
        || (cfg.mode == can_node_pkg::OM_OPEN_DRAIN && !level)
        || (cfg.mode == can_node_pkg::OM_OPEN_SOURCE && level);

    // released pin at reset so the bus stays recessive
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_out <= 1'b0;
            pin_oe_n <= 1'b1;
        end
        else
        begin
            pin_out <= level;
            pin_oe_n <= !drive;
        end
    end
endmodule // line_driver
